// ### rtl/hwmon_pkg.sv
// constants, offsets and types shared by the fan and smi control block
package hwmon_pkg;

   // bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int TEMP_W = 8;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_SRC_SEL  = 8'h4A;
   localparam logic [7:0] IDX_DIV_TWO  = 8'h4B;
   localparam logic [7:0] IDX_INT_CTRL = 8'h4C;
   localparam logic [7:0] IDX_PIN_CTRL = 8'h4D;
   localparam logic [7:0] IDX_BANK_SEL = 8'h4E;
   localparam logic [11:0] ADDR_SRC_SEL  = {2'h0, IDX_SRC_SEL, 2'h0};
   localparam logic [11:0] ADDR_DIV_TWO  = {2'h0, IDX_DIV_TWO, 2'h0};
   localparam logic [11:0] ADDR_INT_CTRL = {2'h0, IDX_INT_CTRL, 2'h0};
   localparam logic [11:0] ADDR_PIN_CTRL = {2'h0, IDX_PIN_CTRL, 2'h0};
   localparam logic [11:0] ADDR_BANK_SEL = {2'h0, IDX_BANK_SEL, 2'h0};
   localparam logic [11:0] ADDR_IRQ_STAT = 12'h200;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h204;
   localparam logic [11:0] ADDR_LIVE     = 12'h208;

   // values after reset
   localparam logic [7:0] RST_SRC_SEL  = 8'h00;
   localparam logic [7:0] RST_DIV_TWO  = 8'h44;
   localparam logic [7:0] RST_INT_CTRL = 8'h10;
   localparam logic [7:0] RST_PIN_CTRL = 8'h95;
   localparam logic [7:0] RST_BANK_SEL = 8'h80;

   // field positions
   localparam int SRC_SEL_LSB      = 5;
   localparam int ADC_SEL_LSB      = 4;
   localparam int AUX_DIV_LSB      = 6;
   localparam int CPU_DIVISOR_BIT_TWO_BIT   = 7;
   localparam int CPU_AUX_MODE_BIT = 6;
   localparam int SYS_ONE_SHOT_BIT = 5;
   localparam int AUX_OVT_DIS_BIT  = 4;
   localparam int CPU_OVT_DIS_BIT  = 3;
   localparam int OVT_POL_BIT      = 2;
   localparam int PIN_TACH_LSB     = 0;
   localparam int PIN_STRIDE       = 2;
   localparam int BANK_FIELD_W     = 3;
   localparam logic [2:0] BANK_ZERO = 3'h0;

   // interrupt status layout
   localparam int IRQ_SYS = 0;
   localparam int IRQ_CPU = 1;
   localparam int IRQ_AUX = 2;
   localparam int IRQ_OVT = 3;
   localparam int IRQ_W   = 4;

   // monitored temperature source codes
   typedef enum logic [2:0] {
      SRC_SYSTEM    = 3'b000,
      SRC_PROCESSOR = 3'b001,
      SRC_AUXILIARY = 3'b010,
      SRC_RESERVED  = 3'b011,
      SRC_PECI_1    = 3'b100,
      SRC_PECI_2    = 3'b101,
      SRC_PECI_3    = 3'b110,
      SRC_PECI_4    = 3'b111
   } temp_source_e;

   // converter clock timing
   localparam int CLK_HZ       = 50_000_000;
   localparam int ADC_BASE_HZ  = 22_500;
   localparam int ADC_BASE_DIV = CLK_HZ / ADC_BASE_HZ;
   localparam logic [6:0] ADC_POST_1  = 7'h01;
   localparam logic [6:0] ADC_POST_4  = 7'h04;
   localparam logic [6:0] ADC_POST_16 = 7'h10;
   localparam logic [6:0] ADC_POST_64 = 7'h40;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### rtl/adc_rate_divider.sv
// converter clock tick generator, base rate divided by 1, 4, 16 or 64
`timescale 1ns/1ns
module adc_rate_divider #(
   parameter int BASE_DIV = hwmon_pkg::ADC_BASE_DIV
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [1:0] rate_sel,
   output logic            tick
);
   import hwmon_pkg::*;

   logic [15:0] base_cnt_ff;
   logic [6:0]  post_cnt_ff;
   logic [6:0]  post_lim;
   logic        base_end;
   logic        tick_ff;

   // post divide per converter clock code
   always_comb begin
      unique case (rate_sel)
         2'b00: post_lim = ADC_POST_1;
         2'b01: post_lim = ADC_POST_4;
         2'b10: post_lim = ADC_POST_16;
         2'b11: post_lim = ADC_POST_64;
      endcase
   end

   assign base_end = (base_cnt_ff == 16'(BASE_DIV - 1));

   // base prescaler free runs at the undivided rate
   always_ff @(posedge aclk) begin
      if (!aresetn || base_end) begin
         base_cnt_ff <= 16'h0000;
      end else begin
         base_cnt_ff <= base_cnt_ff + 16'h0001;
      end
   end

   // a rate change applies to the period in progress; the >= compare leaves no runt period
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         post_cnt_ff <= 7'h00;
      end else if (base_end) begin
         if (post_cnt_ff >= post_lim - 7'h01) begin
            post_cnt_ff <= 7'h00;
         end else begin
            post_cnt_ff <= post_cnt_ff + 7'h01;
         end
      end
   end

   // one-cycle tick per converter clock period
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= base_end && (post_cnt_ff >= post_lim - 7'h01);
      end
   end

   assign tick = tick_ff;

endmodule

// ### rtl/hwmon_fan_smi_control_regs.sv
// fan source, divisor, smi/overtemp and fan pin control register bank
`timescale 1ns/1ns
module hwmon_fan_smi_control_regs #(
   parameter int ADC_BASE_DIV = hwmon_pkg::ADC_BASE_DIV
) (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [hwmon_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [hwmon_pkg::DATA_W-1:0]  s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [hwmon_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [hwmon_pkg::DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic [hwmon_pkg::TEMP_W-1:0]  system_temperature_input,
   input  wire logic [hwmon_pkg::TEMP_W-1:0]  processor_temperature_input,
   input  wire logic [hwmon_pkg::TEMP_W-1:0]  auxiliary_temperature_input,
   input  wire logic [hwmon_pkg::TEMP_W-1:0]  peci_agent_1_temp,
   input  wire logic [hwmon_pkg::TEMP_W-1:0]  peci_agent_2_temp,
   input  wire logic [hwmon_pkg::TEMP_W-1:0]  peci_agent_3_temp,
   input  wire logic [hwmon_pkg::TEMP_W-1:0]  peci_agent_4_temp,
   output logic [hwmon_pkg::TEMP_W-1:0]       processor_fan_output_1_temp,
   output logic                               processor_fan_output_1_valid,
   output logic                               converter_clock_tick,
   output logic [1:0]                         aux_fan_input_0_divisor,
   output logic                               processor_fan_input_1_divisor_bit_two,
   input  wire logic                          sys_temp_over_limit,
   input  wire logic                          cpu_temp_over_limit,
   input  wire logic                          aux_temp_over_limit,
   input  wire logic                          cpu_overtemp_event,
   input  wire logic                          aux_overtemp_event,
   output logic                               overtemp_pin,
   output logic                               management_interrupt_pin_n,
   output logic                               irq,
   input  wire logic [2:0]                    fan_pin_in,
   output logic [2:0]                         fan_pin_out,
   output logic [2:0]                         fan_pin_oe,
   output logic [2:0]                         fan_tach_level
);
   import hwmon_pkg::*;

   // control registers
   logic [7:0] src_sel_ff;
   logic [7:0] div_two_ff;
   logic [7:0] int_ctrl_ff;
   logic [7:0] pin_ctrl_ff;
   logic [7:0] bank_sel_ff;
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_mask_ff;
   logic [IRQ_W-1:0] nxt_irq_stat;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;

   // bus slave state
   logic              awready_ff;
   logic              wready_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              arready_ff;
   logic              rvalid_ff;
   logic [1:0]        rresp_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic              aw_held_ff;
   logic              w_held_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic [7:0]        wdata_ff;
   logic              wstrb0_ff;
   logic              wr_go;
   logic              wr_ok;
   logic              wr_lane;
   logic [DATA_W-1:0] nxt_rdata;
   logic [1:0]        nxt_rresp;

   // block state
   logic              bank_zero;
   temp_source_e      src_code;
   logic [TEMP_W-1:0] temp_ff;
   logic              temp_valid_ff;
   logic              ovt_active;
   logic              ovt_active_ff;
   logic              ovt_pin_ff;
   logic [2:0]        over_prev_ff;
   logic [2:0]        over_now;
   logic [2:0]        over_rise;
   logic [2:0]        over_fall;
   logic              irq_ff;
   logic              smi_n_ff;
   logic [1:0]        aux_div_ff;
   logic              cpu_divisor_bit_two_ff;
   logic [2:0]        pin_sync1_ff;
   logic [2:0]        pin_sync2_ff;
   logic [2:0]        pin_out_ff;
   logic [2:0]        pin_oe_ff;
   logic [2:0]        tach_ff;

   assign bank_zero = (bank_sel_ff[BANK_FIELD_W-1:0] == BANK_ZERO);

   // write fires once both address and data are held
   assign wr_go   = aw_held_ff && w_held_ff && !bvalid_ff;
   assign wr_lane = wr_go && wstrb0_ff;

   // address decode for writes; bank 0 gates the four control registers
   always_comb begin
      unique case (awaddr_ff)
         ADDR_SRC_SEL, ADDR_DIV_TWO,
         ADDR_INT_CTRL, ADDR_PIN_CTRL: wr_ok = bank_zero;
         ADDR_BANK_SEL, ADDR_IRQ_STAT,
         ADDR_IRQ_MASK, ADDR_LIVE:     wr_ok = 1'b1;
         default:                      wr_ok = 1'b0;
      endcase
   end

   // write address channel, one write in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         aw_held_ff <= 1'b0;
         awaddr_ff  <= '0;
      end else if (s_axi_awvalid && awready_ff) begin
         awready_ff <= 1'b0;
         aw_held_ff <= 1'b1;
         awaddr_ff  <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_held_ff <= 1'b0;
      end else if (bvalid_ff && s_axi_bready) begin
         awready_ff <= 1'b1;
      end
   end

   // write data channel, only lane 0 carries register bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_ff <= 1'b1;
         w_held_ff <= 1'b0;
         wdata_ff  <= 8'h00;
         wstrb0_ff <= 1'b0;
      end else if (s_axi_wvalid && wready_ff) begin
         wready_ff <= 1'b0;
         w_held_ff <= 1'b1;
         wdata_ff  <= s_axi_wdata[7:0];
         wstrb0_ff <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_held_ff <= 1'b0;
      end else if (bvalid_ff && s_axi_bready) begin
         wready_ff <= 1'b1;
      end
   end

   // write response; banked-out or unmapped writes answer slverr
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_sel_ff  <= RST_SRC_SEL;
         div_two_ff  <= RST_DIV_TWO;
         int_ctrl_ff <= RST_INT_CTRL;
         pin_ctrl_ff <= RST_PIN_CTRL;
         bank_sel_ff <= RST_BANK_SEL;
      end else if (wr_lane && wr_ok) begin
         unique case (awaddr_ff)
            ADDR_SRC_SEL:  src_sel_ff  <= wdata_ff;
            // software keeps bits 3:2 at 01
            ADDR_DIV_TWO:  div_two_ff  <= wdata_ff;
            ADDR_INT_CTRL: int_ctrl_ff <= wdata_ff;
            ADDR_PIN_CTRL: pin_ctrl_ff <= wdata_ff;
            ADDR_BANK_SEL: bank_sel_ff <= wdata_ff;
            default: ;
         endcase
      end
   end

   // mask register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask_ff <= '0;
      end else if (wr_lane && awaddr_ff == ADDR_IRQ_MASK) begin
         irq_mask_ff <= wdata_ff[IRQ_W-1:0];
      end
   end

   // read decode; data sits in the low byte, upper bits zero
   always_comb begin
      nxt_rdata = '0;
      nxt_rresp = RESP_OKAY;
      unique case (s_axi_araddr)
         ADDR_SRC_SEL, ADDR_DIV_TWO,
         ADDR_INT_CTRL, ADDR_PIN_CTRL: begin
            if (!bank_zero) begin
               nxt_rresp = RESP_SLVERR;
            end else if (s_axi_araddr == ADDR_SRC_SEL) begin
               nxt_rdata[7:0] = src_sel_ff;
            end else if (s_axi_araddr == ADDR_DIV_TWO) begin
               nxt_rdata[7:0] = div_two_ff;
            end else if (s_axi_araddr == ADDR_INT_CTRL) begin
               nxt_rdata[7:0] = int_ctrl_ff;
            end else begin
               nxt_rdata[7:0] = pin_ctrl_ff;
            end
         end
         ADDR_BANK_SEL: nxt_rdata[7:0] = bank_sel_ff;
         ADDR_IRQ_STAT: nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
         ADDR_IRQ_MASK: nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
         ADDR_LIVE:     nxt_rdata[7:0] = {3'h0, ovt_active_ff,
                                          tach_ff, temp_valid_ff};
         default:       nxt_rresp = RESP_SLVERR;
      endcase
   end

   // read channel, data registered at address acceptance
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= '0;
         rresp_ff   <= RESP_OKAY;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= nxt_rdata;
         rresp_ff   <= nxt_rresp;
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   assign src_code = temp_source_e'(src_sel_ff[SRC_SEL_LSB +: 3]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         temp_ff       <= '0;
         temp_valid_ff <= 1'b0;
      end else begin
         temp_valid_ff <= (src_code != SRC_RESERVED);
         unique case (src_code)
            SRC_SYSTEM:    temp_ff <= system_temperature_input;
            SRC_PROCESSOR: temp_ff <= processor_temperature_input;
            SRC_AUXILIARY: temp_ff <= auxiliary_temperature_input;
            SRC_RESERVED:  temp_ff <= '0;
            SRC_PECI_1:    temp_ff <= peci_agent_1_temp;
            SRC_PECI_2:    temp_ff <= peci_agent_2_temp;
            SRC_PECI_3:    temp_ff <= peci_agent_3_temp;
            SRC_PECI_4:    temp_ff <= peci_agent_4_temp;
         endcase
      end
   end

   adc_rate_divider #(
      .BASE_DIV (ADC_BASE_DIV)
   ) u_adc_rate (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .rate_sel (div_two_ff[ADC_SEL_LSB +: 2]),
      .tick     (converter_clock_tick)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aux_div_ff    <= RST_DIV_TWO[AUX_DIV_LSB +: 2];
         cpu_divisor_bit_two_ff <= RST_INT_CTRL[CPU_DIVISOR_BIT_TWO_BIT];
      end else begin
         aux_div_ff    <= div_two_ff[AUX_DIV_LSB +: 2];
         cpu_divisor_bit_two_ff <= int_ctrl_ff[CPU_DIVISOR_BIT_TWO_BIT];
      end
   end

   assign ovt_active =
      (aux_overtemp_event && !int_ctrl_ff[AUX_OVT_DIS_BIT]) ||
      (cpu_overtemp_event && !int_ctrl_ff[CPU_OVT_DIS_BIT]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovt_active_ff <= 1'b0;
         ovt_pin_ff    <= 1'b1;
      end else begin
         ovt_active_ff <= ovt_active;
         ovt_pin_ff    <= int_ctrl_ff[OVT_POL_BIT] ? ovt_active
                                                   : !ovt_active;
      end
   end

   // limit crossings seen as edges of the sensor comparisons
   assign over_now  = {aux_temp_over_limit, cpu_temp_over_limit,
                       sys_temp_over_limit};
   assign over_rise = over_now & ~over_prev_ff;
   assign over_fall = ~over_now & over_prev_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         over_prev_ff <= 3'h0;
      end else begin
         over_prev_ff <= over_now;
      end
   end

   // event sources for the sticky status bits
   always_comb begin
      irq_set = '0;
      irq_set[IRQ_SYS] = int_ctrl_ff[SYS_ONE_SHOT_BIT] ? over_rise[0]
                         : (over_rise[0] || over_fall[0]);
      if (int_ctrl_ff[CPU_AUX_MODE_BIT]) begin
         irq_set[IRQ_CPU] = over_now[1];
         irq_set[IRQ_AUX] = over_now[2];
      end else begin
         irq_set[IRQ_CPU] = over_rise[1] || over_fall[1];
         irq_set[IRQ_AUX] = over_rise[2] || over_fall[2];
      end
      irq_set[IRQ_OVT] = ovt_active && !ovt_active_ff;
   end

   // write one to clear
   assign irq_clr = (wr_lane && awaddr_ff == ADDR_IRQ_STAT)
                    ? wdata_ff[IRQ_W-1:0] : '0;
   // a set in the clearing cycle wins, so no event is dropped
   assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_ff <= '0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
      end
   end

   // level interrupt and its active-low management pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_ff   <= 1'b0;
         smi_n_ff <= 1'b1;
      end else begin
         irq_ff   <= |(nxt_irq_stat & irq_mask_ff);
         smi_n_ff <= !(|(nxt_irq_stat & irq_mask_ff));
      end
   end

   // fan pins: input synchroniser, direction and level per pin
   for (genvar i = 0; i < 3; i++) begin : g_fan_pin
      localparam int TS = PIN_TACH_LSB + PIN_STRIDE * i;

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            pin_sync1_ff[i] <= 1'b0;
            pin_sync2_ff[i] <= 1'b0;
         end else begin
            pin_sync1_ff[i] <= fan_pin_in[i];
            pin_sync2_ff[i] <= pin_sync1_ff[i];
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            pin_oe_ff[i]  <= !RST_PIN_CTRL[TS];
            pin_out_ff[i] <= RST_PIN_CTRL[TS+1];
            tach_ff[i]    <= 1'b0;
         end else begin
            pin_oe_ff[i]  <= !pin_ctrl_ff[TS];
            pin_out_ff[i] <= pin_ctrl_ff[TS+1];
            // driven pins give no tach pulses
            tach_ff[i]    <= pin_ctrl_ff[TS] && pin_sync2_ff[i];
         end
      end
   end

   // outputs, all from flip-flops
   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   assign processor_fan_output_1_temp  = temp_ff;
   assign processor_fan_output_1_valid = temp_valid_ff;
   assign aux_fan_input_0_divisor      = aux_div_ff;
   assign processor_fan_input_1_divisor_bit_two = cpu_divisor_bit_two_ff;
   assign overtemp_pin               = ovt_pin_ff;
   assign management_interrupt_pin_n = smi_n_ff;
   assign irq                        = irq_ff;
   assign fan_pin_out                = pin_out_ff;
   assign fan_pin_oe                 = pin_oe_ff;
   assign fan_tach_level             = tach_ff;

endmodule

// ### bench/hwmon_fan_smi_control_regs_checker.sv
// concurrent checks on bus handshakes, tick and interrupt pins
`timescale 1ns/1ns
module hwmon_fan_smi_control_regs_checker (
   input wire logic aclk,
   aresetn,
   s_axi_awready,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rvalid,
   s_axi_rready,
   converter_clock_tick,
   irq,
   management_interrupt_pin_n
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_write_gap: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid [*2]) else $error("bv");
   a_write_reopen: assert property (
      s_axi_bvalid && s_axi_bready |-> ##[1:2] s_axi_awready) else $error("aw");
   a_write_closed: assert property (
      s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rv");
   a_read_release: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rv held");
   a_read_closed: assert property (
      s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
   a_smi_pair: assert property (
      irq != management_interrupt_pin_n) else $error("smi pin");
   a_tick_spacing: assert property (
      converter_clock_tick |=> !converter_clock_tick [*7]) else $error("tick");
   // main scenarios reached
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (irq);
   cover property (converter_clock_tick);
endmodule
bind hwmon_fan_smi_control_regs
   hwmon_fan_smi_control_regs_checker checker_i (.*);

// ### bench/fan_pin_partner.sv
// far side of fan pins: tach source, driven pins read back
`timescale 1ns/1ns
module fan_pin_partner (
   input wire logic [2:0] fan_pin_oe,
   fan_pin_out,
   tach,
   output logic [2:0] fan_pin_in
);
   // wire level from both drivers
   assign fan_pin_in = fan_pin_oe & fan_pin_out | ~fan_pin_oe & tach;
endmodule

// ### bench/hwmon_fan_smi_control_regs_tb.sv
// self-checking bench for the fan and smi control register bank
`timescale 1ns/1ns
module hwmon_fan_smi_control_regs_tb;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, aux_fan_input_0_divisor, r;
   logic [7:0] system_temperature_input = 8'h11, peci_agent_1_temp = 8'h44;
   logic [7:0] processor_temperature_input = 8'h22, peci_agent_2_temp = 8'h55;
   logic [7:0] auxiliary_temperature_input = 8'h33, peci_agent_3_temp = 8'h66;
   logic [7:0] peci_agent_4_temp = 8'h77, processor_fan_output_1_temp;
   logic processor_fan_output_1_valid, converter_clock_tick, overtemp_pin;
   logic processor_fan_input_1_divisor_bit_two, management_interrupt_pin_n;
   logic sys_temp_over_limit = 1'h0, cpu_temp_over_limit = 1'h0;
   logic aux_temp_over_limit = 1'h0, cpu_overtemp_event = 1'h0;
   logic aux_overtemp_event = 1'h0;
   logic [2:0] fan_pin_in, fan_pin_out, fan_pin_oe, fan_tach_level;
   logic [2:0] tach = 3'h5;
   // interrupt enable bits written to the mask register, 1 lets a bit through
   logic [3:0] m = 4'hF;
   int err_count = 0, compares = 0, n;
   // short base divider keeps rate checks brief
   hwmon_fan_smi_control_regs #(.ADC_BASE_DIV(8))
      hwmon_fan_smi_control_regs_i (.*);
   fan_pin_partner fan_pin_partner_i (.*);
   initial forever #10 aclk = ~aclk;
   task automatic chk(input logic [35:0] s, e);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic complete_run;
      $display("compares=%0d mismatches=%0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic hang;
      err_count++;
      complete_run;
   endtask
   // one axi write or read; each channel dropped once taken
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [7:0] v);
      {s_axi_awaddr, s_axi_araddr} <= {a, a};
      s_axi_wdata <= {24'h0, v};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      n = 0;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (++n > 99) hang;
      end while (!(w ? s_axi_bvalid : s_axi_rvalid));
      {r, d} = w ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
      {s_axi_bready, s_axi_rready} <= 2'h0;
      @(posedge aclk);
   endtask
   task automatic t_reset;
      logic [7:0] rv [5] = '{8'h00, 8'h44, 8'h10, 8'h95, 8'h80};
      foreach (rv[i]) begin
         bus(1'h0, 12'h128 + 12'(4 * i), 8'h0);
         chk({r, d}, {2'h0, 24'h0, rv[i]});
      end
      bus(1'h0, 12'h300, 8'h0);
      chk({r, d}, {2'h2, 32'h0});
   endtask
   task automatic t_src;
      logic [7:0] tv [8] = '{8'h11, 8'h22, 8'h33, 8'h00,
                             8'h44, 8'h55, 8'h66, 8'h77};
      foreach (tv[c]) begin
         bus(1'h1, 12'h128, {3'(c), 5'h15});
         chk(processor_fan_output_1_temp, tv[c]);
         chk(processor_fan_output_1_valid, c != 3);
      end
   endtask
   task automatic t_pins;
      bus(1'h1, 12'h134, 8'h2A);
      chk({fan_pin_oe, fan_pin_out}, 6'h3F);
      bus(1'h1, 12'h134, 8'h08);
      chk({fan_pin_oe, fan_pin_out, fan_tach_level}, 9'h1D0);
      bus(1'h1, 12'h134, 8'h95);
      repeat (3) @(posedge aclk);
      chk({fan_pin_oe, fan_tach_level}, 6'h05);
      bus(1'h0, 12'h208, 8'h0);
      chk(d, 32'h0B);
   endtask
   task automatic t_ovt;
      logic [11:0] tv [5] = '{12'h104, 12'h185, 12'h1C4, 12'h0C3, 12'h142};
      foreach (tv[i]) begin
         {cpu_overtemp_event, aux_overtemp_event} <= tv[i][2:1];
         bus(1'h1, 12'h130, tv[i][11:4]);
         chk(overtemp_pin, tv[i][0]);
      end
      {cpu_overtemp_event, aux_overtemp_event} <= 2'h0;
      bus(1'h1, 12'h130, 8'h90);
      chk(processor_fan_input_1_divisor_bit_two, 1'h1);
      bus(1'h1, 12'h200, 8'h0F);
   endtask
   // drive limit levels, then read, judge and clear status
   task automatic ev(input logic [2:0] lv, input logic [3:0] e);
      {aux_temp_over_limit, cpu_temp_over_limit, sys_temp_over_limit} <= lv;
      repeat (3) @(posedge aclk);
      bus(1'h0, 12'h200, 8'h0);
      chk({irq, d}, {|(e & m), 28'h0, e});
      bus(1'h1, 12'h200, 8'h0F);
   endtask
   task automatic t_irq;
      bus(1'h1, 12'h204, {4'h0, m});
      bus(1'h1, 12'h130, 8'h10);
      ev(3'h1, 4'h1);
      ev(3'h0, 4'h1);
      bus(1'h1, 12'h130, 8'h30);
      ev(3'h1, 4'h1);
      ev(3'h0, 4'h0);
      ev(3'h2, 4'h2);
      ev(3'h2, 4'h0);
      bus(1'h1, 12'h130, 8'h70);
      ev(3'h6, 4'h6);
      ev(3'h1, 4'h7);
      m = 4'hE;
      bus(1'h1, 12'h204, {4'h0, m});
      bus(1'h0, 12'h204, 8'h0);
      chk(d, {28'h0, m});
      ev(3'h0, 4'h0);
      ev(3'h1, 4'h1);
   endtask
   task automatic t_bank;
      bus(1'h1, 12'h138, 8'h81);
      bus(1'h1, 12'h128, 8'h20);
      chk(r, 2'h2);
      bus(1'h0, 12'h128, 8'h0);
      chk(r, 2'h2);
      bus(1'h1, 12'h138, 8'h80);
      bus(1'h0, 12'h128, 8'h0);
      chk({r, d}, 34'hF5);
   endtask
   task automatic t_adc;
      for (int c = 0; c < 4; c++) begin
         bus(1'h1, 12'h12C, 8'h84 | 8'(c << 4));
         repeat (3) begin
            n = 0;
            do begin
               @(posedge aclk);
               if (++n > 999) hang;
            end while (!converter_clock_tick);
         end
         chk(n, 8 << (2 * c));
      end
      chk(aux_fan_input_0_divisor, 2'h2);
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_reset;
      $display("reset values done");
      t_src;
      $display("source select done");
      t_pins;
      $display("fan pins done");
      t_ovt;
      $display("overtemp pin done");
      t_irq;
      $display("interrupt modes done");
      t_bank;
      $display("bank select done");
      t_adc;
      $display("converter rate done");
      complete_run;
   end
endmodule
